//--- hdl/phy_strap_pin_mux.sv
// Pin-function multiplexer for the address, test and combo-mode strap pins.
//
// Overview of operation
// - Repeater: address bits 0-3 from straps.
// - Repeater: fifth address bit from extra strap.
// - Adapter: drive slave tri-state with combo enable.
// - Slave link input active low in combo.
// - Test: strap bit 1 is test execute.
// - Test: strap bit 0 is test clock.
// - Repeater: autoneg disabled when strap high.
// - Adapter: combo enable selects combo mode.
// - Combo mode repurposes link and tri-state pins.
// - Bypass strap skips scrambler and descrambler.
//
// Things a user of this block should know:
// Mode and test enable come from the control register, never from pins, so
// a strap may be decoded under the old mode for a cycle while software
// changes modes.
// Every strap pin passes two synchroniser stages and then the output stage,
// so a pin change shows at the outputs on the third clock edge after it.
// The test clock pin is sampled here, not used as a clock, which limits it
// to rates well below the device clock.
// The shared fourth address pin is driven only in adapter mode with combo
// mode on, so a repeater board keeps its address strap undisturbed.
// The device address is held while the pins serve test or adapter uses, so
// the rest of the device keeps answering at its last address.
// A control write lands at the edge that raises ready, one edge before the
// bus sees the transfer end; nothing reads the control word in between.
// An unmapped offset reads as zero, drops any write and answers with an
// error response.
`timescale 1ns/1ps
module phy_strap_pin_mux
  import strap_mux_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  input wire logic i_addr_strap_bit4,
  input wire logic i_addr_strap_bit3,
  output logic o_addr_strap_bit3,
  output logic o_addr_strap_bit3_oe,
  input wire logic i_autoneg_off_strap,
  input wire logic i_scrambler_bypass_strap,
  output logic [4:0] o_dev_addr,
  output logic o_autoneg_disable,
  output logic o_scrambler_bypass,
  output logic o_combo_mode,
  output logic o_slave_link_up,
  output logic o_test_exec_cmd,
  output logic o_test_clk,
  output logic o_test_data
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  // Wiring between the synchroniser, the register slave and the decode.
  strap_pins_t pins_async;
  strap_pins_t pins;
  logic [2:0] ctrl;
  logic [31:0] status_word;
  logic [31:0] addr_word;

  // All strap pins are asynchronous, so each one is synchronised first.
  // The bundle is synchronised bit by bit; bits that change together may
  // land one cycle apart, which is harmless for slow board straps but means
  // a moving address is only trustworthy once it has been still for a while.
  assign pins_async = '{
    addr: {i_addr_strap_bit4, i_addr_strap_bit3, i_addr_strap_bit2,
           i_addr_strap_bit1, i_addr_strap_bit0},
    autoneg_off: i_autoneg_off_strap,
    scr_bypass: i_scrambler_bypass_strap
  };

  // The synchroniser width follows the bundle, so a new strap needs no edit here.
  pin_sync #(
    .WIDTH($bits(strap_pins_t))
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(pins_async),
    .o_sync(pins)
  );

  // ---------------------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------------------
  // The register slave owns the control word; this module only reads it and
  // hands back the decoded status for software to inspect.
  apb_regs u_regs (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_status(status_word),
    .i_addr_view(addr_word),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_ctrl(ctrl)
  );

  // ---------------------------------------------------------------------------
  // Function decode
  // ---------------------------------------------------------------------------
  // The pad enable rides in the same state as the functions, so both change on one edge.
  typedef struct packed {
    strap_func_t func;
    logic hiz_oe;
  } mux_state_t;

  // One struct of state and its next value; sel is the decoded pin function.
  mux_state_t state_reg;
  mux_state_t state_next;
  pin_func_t sel;

  // Test enable overrides the mode bit, so a board in test never enters combo mode.
  // The priority is fixed here in one place so that every output below agrees
  // on which function the pins carry in a given cycle.
  always_comb begin
    if (ctrl[CTRL_TEST_BIT]) begin
      sel = FUNC_TEST;
    end else if (ctrl[CTRL_MODE_BIT]) begin
      sel = FUNC_ADAPTER;
    end else begin
      sel = FUNC_REPEATER;
    end
  end

  // Each output is rebuilt every cycle from the selected pin function.
  // Starting from zero keeps every function that is not selected at its idle
  // level, so a stale test clock or combo flag cannot linger after a mode
  // change. Only the device address is held, because the rest of the device
  // keeps answering at its last address while the pins are lent elsewhere.
  always_comb begin
    state_next = '0;
    state_next.func.scr_bypass = pins.scr_bypass;
    state_next.func.dev_addr = state_reg.func.dev_addr;
    case (sel)
      FUNC_REPEATER: begin
        // Every address bit and the autoneg strap keep their plain meaning.
        state_next.func.dev_addr[3:0] = pins.addr[3:0];
        state_next.func.dev_addr[4] = pins.addr[4];
        state_next.func.autoneg_disable = pins.autoneg_off;
      end
      FUNC_ADAPTER: begin
        // The autoneg strap becomes the combo enable; link and pad follow it.
        state_next.func.combo_mode = pins.autoneg_off;
        if (pins.autoneg_off) begin
          state_next.func.slave_link_up = !pins.addr[2];
          state_next.func.slave_hiz = ctrl[CTRL_HIZ_BIT];
          state_next.hiz_oe = 1'b1;
        end
      end
      FUNC_TEST: begin
        // Bits 0, 1 and 4 carry the test clock, execute command and test data.
        state_next.func.test_exec = pins.addr[1];
        state_next.func.test_clk = pins.addr[0];
        state_next.func.test_data = pins.addr[4] & pins.addr[1];
      end
      default: begin
        // Unused code: hold the address and leave every function idle.
        state_next.func.dev_addr = state_reg.func.dev_addr;
      end
    endcase
  end

  // Outputs are registered so the pin mux never glitches onto the device.
  // The cost is one more cycle of latency, which straps never notice.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Status and outputs
  // ---------------------------------------------------------------------------
  // Status word for software: one bit per decoded function, with the pad
  // enable on top so a driver can tell whether the shared pin is driven.
  assign status_word = {23'h00_0000, state_reg.hiz_oe, state_reg.func.test_data,
                        state_reg.func.test_clk, state_reg.func.test_exec,
                        state_reg.func.slave_hiz, state_reg.func.slave_link_up,
                        state_reg.func.combo_mode, state_reg.func.scr_bypass,
                        state_reg.func.autoneg_disable};
  // Address view: the five-bit device address, zero extended.
  assign addr_word = {27'h000_0000, state_reg.func.dev_addr};
  // Every output comes straight from the registered state.
  assign o_dev_addr = state_reg.func.dev_addr;
  assign o_autoneg_disable = state_reg.func.autoneg_disable;
  assign o_scrambler_bypass = state_reg.func.scr_bypass;
  assign o_combo_mode = state_reg.func.combo_mode;
  assign o_slave_link_up = state_reg.func.slave_link_up;
  // The shared fourth address pin: value and enable leave the same register.
  assign o_addr_strap_bit3 = state_reg.func.slave_hiz;
  assign o_addr_strap_bit3_oe = state_reg.hiz_oe;
  // Test functions, all idle low outside test mode.
  assign o_test_exec_cmd = state_reg.func.test_exec;
  assign o_test_clk = state_reg.func.test_clk;
  assign o_test_data = state_reg.func.test_data;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Every check runs on the one device clock and sleeps through reset.
  // Each output is registered, so a property looks at the decode inputs on
  // one edge and at the outputs on the next.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // Repeater mode: address and autoneg straps pass straight through.
  // The address checks ask for two repeater cycles in a row, so an output
  // built just before a mode change is never held to the new mode.
  AST_ADDR_LOW: assert property ((sel == FUNC_REPEATER) ##1 (sel == FUNC_REPEATER)
    |-> o_dev_addr[3:0] == $past(pins.addr[3:0])) else $error("addr low bad");
  AST_ADDR_HIGH: assert property ((sel == FUNC_REPEATER) ##1 (sel == FUNC_REPEATER)
    |-> o_dev_addr[4] == $past(pins.addr[4])) else $error("addr bit4 bad");
  AST_AUTONEG: assert property ((sel == FUNC_REPEATER)
    |=> o_autoneg_disable == $past(pins.autoneg_off)) else $error("autoneg bad");
  // A repeater board must never see the slave interface come alive.
  AST_REPEATER_QUIET: assert property ((sel == FUNC_REPEATER)
    |=> !o_combo_mode && !o_addr_strap_bit3_oe) else $error("repeater leak");

  // Adapter mode: the autoneg strap turns into the combo enable, and only
  // with combo on does the block drive the shared pin and read the link.
  // A slip here would let two chips fight over the shared pin.
  AST_COMBO: assert property ((sel == FUNC_ADAPTER)
    |=> o_combo_mode == $past(pins.autoneg_off)) else $error("combo bad");
  AST_COMBO_QUIET: assert property ((sel != FUNC_ADAPTER)
    |=> !o_combo_mode) else $error("combo outside adapter");
  AST_HIZ_DRIVE: assert property (o_addr_strap_bit3_oe
    |-> $past(sel) == FUNC_ADAPTER && $past(pins.autoneg_off)) else $error("oe bad");
  AST_HIZ_VALUE: assert property ((sel == FUNC_ADAPTER && pins.autoneg_off)
    |=> o_addr_strap_bit3 == $past(ctrl[CTRL_HIZ_BIT])) else $error("hiz bad");
  // The pad value only matters while it is driven, so it rests low otherwise.
  AST_HIZ_REST: assert property (o_addr_strap_bit3
    |-> o_addr_strap_bit3_oe) else $error("hiz value without drive");
  AST_LINK_LOW: assert property (sel == FUNC_ADAPTER && pins.autoneg_off
    && !pins.addr[2] |=> o_slave_link_up) else $error("link bad");
  // A released link line means the slave shows no valid link.
  AST_LINK_HIGH: assert property (sel == FUNC_ADAPTER && pins.autoneg_off
    && pins.addr[2] |=> !o_slave_link_up) else $error("link high bad");
  AST_COMBO_ONLY: assert property (!o_combo_mode
    |-> !o_addr_strap_bit3_oe && !o_slave_link_up) else $error("pins leak");
  AST_HIZ_OFF: assert property (!(sel == FUNC_ADAPTER && pins.autoneg_off)
    |=> !o_addr_strap_bit3_oe && !o_addr_strap_bit3) else $error("pad driven outside combo");

  // Test mode takes the pins over whatever the mode bit says.
  // The idle check guards against a test clock that keeps toggling after exit.
  AST_TEST_EXEC: assert property ((sel == FUNC_TEST)
    |=> o_test_exec_cmd == $past(pins.addr[1])) else $error("exec bad");
  AST_TEST_CLK: assert property ((sel == FUNC_TEST)
    |=> o_test_clk == $past(pins.addr[0])) else $error("tck bad");
  // Test data is only meaningful while the execute command is up.
  AST_TEST_DATA: assert property ((sel == FUNC_TEST)
    |=> o_test_data == ($past(pins.addr[4]) && $past(pins.addr[1]))) else $error("tdata bad");
  AST_TEST_IDLE: assert property ((sel != FUNC_TEST)
    |=> !o_test_exec_cmd && !o_test_clk && !o_test_data) else $error("test leak");
  AST_TEST_FIRST: assert property ((ctrl[CTRL_TEST_BIT])
    |=> !o_combo_mode && !o_autoneg_disable) else $error("test order bad");

  // Independent of mode: the bypass strap always passes through, and the
  // address stays put while the pins are lent to another function.
  // Autoneg must not be switched off by a strap that now means combo enable.
  AST_SCR: assert property (1'b1 |=> o_scrambler_bypass == $past(pins.scr_bypass))
    else $error("bypass bad");
  AST_ADDR_HOLD: assert property ((sel != FUNC_REPEATER)
    |=> $stable(o_dev_addr)) else $error("addr moved");
  AST_AUTONEG_QUIET: assert property ((sel != FUNC_REPEATER)
    |=> !o_autoneg_disable) else $error("autoneg outside repeater");

  // Covers for the main scenarios: each mode reached with its key function up,
  // and the slave forced quiet through the shared pin.
  COV_REPEATER: cover property (sel == FUNC_REPEATER ##1 o_autoneg_disable);
  COV_COMBO: cover property (o_combo_mode && o_slave_link_up);
  COV_SLAVE_OFF: cover property (o_combo_mode && o_addr_strap_bit3_oe && o_addr_strap_bit3);
  COV_TEST: cover property (o_test_exec_cmd && o_test_clk);
  COV_TEST_DATA: cover property (o_test_data);

endmodule

//--- hdl/strap_mux_pkg.sv
// Package with the pin-mux types, modes and constants of the strap block.
package strap_mux_pkg;

  // ---------------------------------------------------------------------------
  // Register map and layout
  // ---------------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STAT_OFFSET = 12'h004;
  localparam logic [11:0] ADDR_OFFSET = 12'h008;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam int CTRL_HIZ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam int ADDR_BITS = 5;

  // ---------------------------------------------------------------------------
  // Pin function selection
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FUNC_REPEATER = 2'b00,
    FUNC_ADAPTER = 2'b01,
    FUNC_TEST = 2'b10
  } pin_func_t;

  // Raw strap pin levels after synchronisation.
  typedef struct packed {
    logic [4:0] addr;
    logic autoneg_off;
    logic scr_bypass;
  } strap_pins_t;

  // Decoded functions that the rest of the device uses.
  typedef struct packed {
    logic [4:0] dev_addr;
    logic autoneg_disable;
    logic scr_bypass;
    logic combo_mode;
    logic slave_link_up;
    logic slave_hiz;
    logic test_exec;
    logic test_clk;
    logic test_data;
  } strap_func_t;

endpackage

//--- hdl/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb begin
    state_next = state_reg;
    state_next.meta = i_async;
    state_next.sync = state_reg.meta;
  end

  // Both stages clear on reset to a constant.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.sync;

endmodule

//--- hdl/apb_regs.sv
// APB slave holding the control word and showing decoded strap status.
`timescale 1ns/1ps
module apb_regs
  import strap_mux_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_addr_view,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [2:0] o_ctrl
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } apb_state_t;

  apb_state_t state_reg;
  apb_state_t state_next;
  logic hit;

  // One wait state: ready rises at the edge ending the first access cycle and ends the transfer in the second.
  always_comb begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.err = 1'b0;
    hit = 1'b1;
    if (i_psel && i_penable && !state_reg.ready) begin
      state_next.ready = 1'b1;
      state_next.rdata = DATA_ZERO;
      if (i_paddr == CTRL_OFFSET) begin
        if (i_pwrite) begin
          state_next.ctrl = i_pwdata[2:0];
        end
        state_next.rdata = {29'h0000_0000, state_reg.ctrl};
      end else if (i_paddr == STAT_OFFSET) begin
        state_next.rdata = i_status;
      end else if (i_paddr == ADDR_OFFSET) begin
        state_next.rdata = i_addr_view;
      end else begin
        hit = 1'b0;
      end
      state_next.err = !hit;
    end
  end

  // Control word resets to repeater mode with test off.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '{ctrl: CTRL_RESET, rdata: DATA_ZERO, ready: 1'b0, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_prdata = state_reg.rdata;
  assign o_pready = state_reg.ready;
  assign o_pslverr = state_reg.err;
  assign o_ctrl = state_reg.ctrl;

endmodule

//--- tb/strap_board_model.sv
// Board strap resistors and the companion slave PHY as seen from the strap pins.
`timescale 1ns/1ps
module strap_board_model (
  input wire logic [4:0] i_addr_set,
  input wire logic i_an_strap,
  input wire logic i_bypass,
  input wire logic i_adapter,
  input wire logic i_link_ok,
  input wire logic i_dev_bit3,
  input wire logic i_dev_bit3_oe,
  output logic [4:0] o_addr_pins,
  output logic o_an_pin,
  output logic o_bypass_pin,
  output logic o_slave_off
);
  logic bit3_wire;
  // The shared bit 3 wire follows the device while it drives, else the strap resistor.
  assign bit3_wire = i_dev_bit3_oe ? i_dev_bit3 : i_addr_set[3];
  // The slave goes quiet when its tri-state request and combo enable are both high.
  assign o_slave_off = bit3_wire & i_an_strap;
  // A quiet slave releases the link line, so the pull-up shows no link.
  always_comb begin
    o_addr_pins = i_addr_set;
    o_addr_pins[3] = bit3_wire;
    if (i_adapter && i_an_strap) begin
      o_addr_pins[2] = o_slave_off ? 1'b1 : ~i_link_ok;
    end
  end
  assign o_an_pin = i_an_strap;
  assign o_bypass_pin = i_bypass;
endmodule

//--- tb/test_phy_strap_pin_mux.sv
// Self-checking bench of the strap pin multiplexer with its board model.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_phy_strap_pin_mux;
  import strap_mux_pkg::*;
  logic i_clk, i_rstn, psel, penable, pwrite, pready, pslverr, hiz, hiz_oe, off;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] addr_set, pins, dev_addr, last_addr;
  logic an_strap, bypass, adapter, link_ok, an_pin, by_pin, err;
  logic an_dis, scr_by, combo, link_up, t_exec, t_clk, t_data;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  strap_board_model u_board (.i_addr_set(addr_set), .i_an_strap(an_strap), .i_bypass(bypass),
    .i_adapter(adapter), .i_link_ok(link_ok), .i_dev_bit3(hiz), .i_dev_bit3_oe(hiz_oe),
    .o_addr_pins(pins), .o_an_pin(an_pin), .o_bypass_pin(by_pin), .o_slave_off(off));

  phy_strap_pin_mux u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_addr_strap_bit0(pins[0]), .i_addr_strap_bit1(pins[1]), .i_addr_strap_bit2(pins[2]),
    .i_addr_strap_bit4(pins[4]), .i_addr_strap_bit3(pins[3]), .o_addr_strap_bit3(hiz),
    .o_addr_strap_bit3_oe(hiz_oe), .i_autoneg_off_strap(an_pin),
    .i_scrambler_bypass_strap(by_pin), .o_dev_addr(dev_addr), .o_autoneg_disable(an_dis),
    .o_scrambler_bypass(scr_by), .o_combo_mode(combo), .o_slave_link_up(link_up),
    .o_test_exec_cmd(t_exec), .o_test_clk(t_clk), .o_test_data(t_data));

  // ---------------------------------------------------------------------------
  // Clock, timeout and closing report
  // ---------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // The whole run needs well under a thousand cycles; the ceiling leaves room.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Bus cycles and expectations
  // ---------------------------------------------------------------------------
  // Holds the request until pready is sampled high, so slow answers are fine too.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Test data only counts while the execute command is up.
  function automatic logic exp_tdata(input logic [4:0] s);
    return s[4] & s[1];
  endfunction

  task automatic settle();
    repeat (6) @(posedge i_clk);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {addr_set, an_strap, bypass, adapter, link_ok} = '0;
    i_rstn = 1'b0;
    void'($urandom(47));
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    apb(1'b0, CTRL_OFFSET, DATA_ZERO);
    `CHK(rd[2:0], CTRL_RESET)
    apb(1'b0, 12'h00C, DATA_ZERO);
    `CHK({err, rd}, {1'b1, DATA_ZERO})
    $display("test reset and bus done");
    for (int i = 0; i < 10; i++) begin
      addr_set <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      an_strap <= 1'($urandom);
      bypass <= 1'($urandom);
      settle();
      `CHK(dev_addr, addr_set)
      `CHK(an_dis, an_strap)
      `CHK(scr_by, bypass)
      `CHK({combo, hiz_oe}, 2'h0)
    end
    last_addr = addr_set;
    $display("test repeater straps done");
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    adapter <= 1'b1;
    an_strap <= 1'b1;
    link_ok <= 1'b1;
    settle();
    `CHK({combo, an_dis}, 2'h2)
    `CHK({hiz_oe, hiz}, 2'h2)
    `CHK(link_up, 1'b1)
    link_ok <= 1'b0;
    settle();
    `CHK(link_up, 1'b0)
    link_ok <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h0000_0005);
    settle();
    `CHK({hiz_oe, hiz, off}, 3'h7)
    `CHK(link_up, 1'b0)
    an_strap <= 1'b0;
    settle();
    `CHK({combo, hiz_oe}, 2'h0)
    $display("test adapter combo done");
    adapter <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CTRL_OFFSET, (i % 2 == 0) ? 32'h0000_0002 : 32'h0000_0003);
      addr_set <= (i == 0) ? 5'h15 : 5'($urandom);
      settle();
      `CHK(t_exec, addr_set[1])
      `CHK(t_clk, addr_set[0])
      `CHK(t_data, exp_tdata(addr_set))
      `CHK(dev_addr, last_addr)
    end
    $display("test test mode done");
    wrap_up();
  end
endmodule
